// File: bsu_cfg.svh
// Register offsets, field positions, reset values and encodings for the supply monitor control
`ifndef BSU_CFG_SVH
`define BSU_CFG_SVH
`define BSU_OFS_CONFIG      8'h09
`define BSU_OFS_THR_ONE     8'h0A
`define BSU_OFS_THR_TWO     8'h0B
`define BSU_RST_CONFIG      8'h00
`define BSU_RST_THR_ONE     8'h92
`define BSU_RST_THR_TWO     8'h8D
`define BSU_LVLEN_MSB       7
`define BSU_LVLEN_LSB       6
`define BSU_UVSEL_MSB       2
`define BSU_UVSEL_LSB       0
`define BSU_LVLEN_OFF       2'h0
`define BSU_LVLEN_ONE       2'h1
`define BSU_LVLEN_BOTH      2'h2
`define BSU_UV_BASE_MV      12'h9C4
`define BSU_UV_STEP_MV      12'h064
`endif

// File: bsu_pkg.sv
// Types shared by the supply monitor control modules
package bsu_pkg;
    typedef enum logic [1:0] {
        BSU_CLAMP_NORMAL = 2'h0,
        BSU_CLAMP_ONE    = 2'h1,
        BSU_CLAMP_TWO    = 2'h2
    } bsu_clamp_e;
    typedef enum logic [1:0] {
        BSU_ST_STANDBY = 2'h0,
        BSU_ST_ACTIVE  = 2'h1,
        BSU_ST_EFFECT  = 2'h2,
        BSU_ST_LOCKOUT = 2'h3
    } bsu_state_e;
endpackage : bsu_pkg

// File: bsu_sel_if.sv
// Carrier between the top and the clamp selector
`timescale 1ns/1ps
interface bsu_sel_if;
    import bsu_pkg::*;
    logic [1:0] level_enable;
    logic [7:0] thr_one;
    logic [7:0] thr_two;
    logic [7:0] supply_sample;
    bsu_clamp_e clamp;
    modport top (output level_enable, output thr_one, output thr_two,
                 output supply_sample, input clamp);
    modport sel (input level_enable, input thr_one, input thr_two,
                 input supply_sample, output clamp);
endinterface : bsu_sel_if

// File: bsu_clamp_sel.sv
// Combinational clamp choice from the supply sample and battery thresholds
`timescale 1ns/1ps
`include "bsu_cfg.svh"
module bsu_clamp_sel
    import bsu_pkg::*;
(
    bsu_sel_if.sel s    // Thresholds, sample and chosen clamp
);
    logic below_one;
    logic below_two;
    assign below_one = s.supply_sample < s.thr_one;
    assign below_two = s.supply_sample < s.thr_two;
    always_comb begin
        s.clamp = BSU_CLAMP_NORMAL;
        case (s.level_enable)
            `BSU_LVLEN_ONE: begin
                if (below_one) s.clamp = BSU_CLAMP_ONE;
            end
            `BSU_LVLEN_BOTH: begin
                // Level two wins even if thresholds are programmed inverted
                if (below_two) s.clamp = BSU_CLAMP_TWO;
                else if (below_one) s.clamp = BSU_CLAMP_ONE;
            end
            default: s.clamp = BSU_CLAMP_NORMAL;
        endcase
    end
endmodule : bsu_clamp_sel

// File: bsu_top.sv
// Supply monitor control: lockout threshold, battery saver levels, clamp select
// Function
// - Level enable 0 disables, 1 enables level one, 2 enables both levels.
// - Lockout select codes 0..7 map 2.5 V to 3.2 V in 0.1 V steps.
// - Supply below lockout threshold turns output stage off and forces standby.
// - Level one enabled and supply below threshold one selects clamp one.
// - Level two enabled and supply below threshold two selects clamp two.
// - Supply compared once at effect start; clamp held for whole effect.
`timescale 1ns/1ps
`include "bsu_cfg.svh"
module bsu_top
    import bsu_pkg::*;
(
    input  wire logic       mclk,            // Core clock, 20 MHz
    input  wire logic       arst_n,          // Asynchronous reset, active low
    input  wire logic       reg_wr,          // Register write strobe
    input  wire logic [7:0] reg_addr,        // Register offset
    input  wire logic [7:0] reg_wdata,       // Register write data
    output logic      [7:0] reg_rdata,       // Registered read data
    input  wire logic       supply_below_uv, // Comparator flag: supply under threshold
    input  wire logic [7:0] supply_sample,   // Digitized supply level
    input  wire logic       effect_start,    // Pulse: an effect begins
    input  wire logic       effect_end,      // Pulse: effect finished or cancelled
    input  wire logic       wake_request,    // Leave standby
    output logic      [2:0] uv_threshold_sel,// Lockout select to comparator
    output logic     [11:0] uv_threshold_mv, // Selected lockout level in mV
    output logic            output_stage_en, // Output stage enable
    output logic            standby,         // Device in standby
    output logic      [1:0] clamp_select     // 0 normal, 1 limit one, 2 limit two
);
    function automatic logic [11:0] uv_mv(input logic [2:0] code);
        uv_mv = `BSU_UV_BASE_MV + 12'(code) * `BSU_UV_STEP_MV;
    endfunction : uv_mv

    // Field extraction from the config byte
    function automatic logic [2:0] uv_code(input logic [7:0] cfg);
        uv_code = cfg[`BSU_UVSEL_MSB:`BSU_UVSEL_LSB];
    endfunction : uv_code

    function automatic logic [1:0] level_code(input logic [7:0] cfg);
        level_code = cfg[`BSU_LVLEN_MSB:`BSU_LVLEN_LSB];
    endfunction : level_code

    // One-hot register hit: [2] config, [1] threshold one, [0] threshold two
    function automatic logic [2:0] reg_hit(input logic [7:0] addr);
        case (addr)
            `BSU_OFS_CONFIG:  reg_hit = 3'h4;
            `BSU_OFS_THR_ONE: reg_hit = 3'h2;
            `BSU_OFS_THR_TWO: reg_hit = 3'h1;
            default:          reg_hit = 3'h0;
        endcase
    endfunction : reg_hit

    // Standby and lockout both keep the stage off and report standby
    function automatic logic is_quiet(input bsu_state_e st);
        is_quiet = (st == BSU_ST_STANDBY) || (st == BSU_ST_LOCKOUT);
    endfunction : is_quiet

    logic [7:0] config_q, config_d;
    logic [7:0] thr_one_q, thr_one_d;
    logic [7:0] thr_two_q, thr_two_d;
    logic [7:0] rdata_q, rdata_d;
    bsu_state_e state_q, state_d;
    bsu_clamp_e clamp_q, clamp_d;
    logic [11:0] uvmv_q, uvmv_d;
    logic       stage_q, stage_d;
    logic       stby_q, stby_d;
    logic [2:0] wr_hit;
    logic [2:0] rd_hit;

    bsu_sel_if sel_bus ();
    assign sel_bus.level_enable  = level_code(config_q);
    assign sel_bus.thr_one       = thr_one_q;
    assign sel_bus.thr_two       = thr_two_q;
    assign sel_bus.supply_sample = supply_sample;

    bsu_clamp_sel u_sel (
        .s (sel_bus.sel)
    );

    // Register writes; reserved config bits are stored and read back
    always_comb begin
        config_d  = config_q;
        thr_one_d = thr_one_q;
        thr_two_d = thr_two_q;
        wr_hit    = reg_wr ? reg_hit(reg_addr) : 3'h0;
        if (wr_hit[2]) begin
            config_d = reg_wdata;
        end
        if (wr_hit[1]) begin
            thr_one_d = reg_wdata;
        end
        if (wr_hit[0]) begin
            thr_two_d = reg_wdata;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            config_q  <= `BSU_RST_CONFIG;
            thr_one_q <= `BSU_RST_THR_ONE;
            thr_two_q <= `BSU_RST_THR_TWO;
        end else begin
            config_q  <= config_d;
            thr_one_q <= thr_one_d;
            thr_two_q <= thr_two_d;
        end
    end

    // Read data is registered: it shows the addressed register one edge later
    always_comb begin
        rd_hit = reg_hit(reg_addr);
        case (rd_hit)
            3'h4:    rdata_d = config_q;
            3'h2:    rdata_d = thr_one_q;
            3'h1:    rdata_d = thr_two_q;
            default: rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // Informational lockout level, one cycle behind the select field
    always_comb begin
        uvmv_d = uv_mv(uv_code(config_q));
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            uvmv_q <= `BSU_UV_BASE_MV;
        end else begin
            uvmv_q <= uvmv_d;
        end
    end

    // Power state
    always_comb begin
        state_d = state_q;
        case (state_q)
            BSU_ST_STANDBY: begin
                if (wake_request) begin
                    state_d = BSU_ST_ACTIVE;
                end
            end
            BSU_ST_ACTIVE: begin
                if (!wake_request) begin
                    state_d = BSU_ST_STANDBY;
                end else if (effect_start) begin
                    state_d = BSU_ST_EFFECT;
                end
            end
            BSU_ST_EFFECT: begin
                // Dropping the wake request does not cut a running effect short
                if (effect_end) begin
                    state_d = BSU_ST_ACTIVE;
                end
            end
            BSU_ST_LOCKOUT: begin
                // Exit straight to standby; a wake request still held moves the device to active one edge later
                if (!supply_below_uv) begin
                    state_d = BSU_ST_STANDBY;
                end
            end
            default: state_d = BSU_ST_STANDBY;
        endcase
        // Lockout overrides every state, a running effect included
        if (supply_below_uv) begin
            state_d = BSU_ST_LOCKOUT;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= BSU_ST_STANDBY;
        end else begin
            state_q <= state_d;
        end
    end

    // Clamp latch: the sample is looked at only on the start edge, then frozen
    always_comb begin
        clamp_d = clamp_q;
        if ((state_q == BSU_ST_ACTIVE) && (state_d == BSU_ST_EFFECT)) begin
            clamp_d = sel_bus.clamp;
        end else if (state_d != BSU_ST_EFFECT) begin
            clamp_d = BSU_CLAMP_NORMAL;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            clamp_q <= BSU_CLAMP_NORMAL;
        end else begin
            clamp_q <= clamp_d;
        end
    end

    // Flag feeds the enable directly so the stage drops on the very next edge
    always_comb begin
        stage_d = !supply_below_uv && (state_d == BSU_ST_EFFECT);
        stby_d  = is_quiet(state_d);
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            stage_q <= 1'b0;
            stby_q  <= 1'b1;
        end else begin
            stage_q <= stage_d;
            stby_q  <= stby_d;
        end
    end

    assign reg_rdata        = rdata_q;
    assign uv_threshold_sel = uv_code(config_q);
    assign uv_threshold_mv  = uvmv_q;
    assign output_stage_en  = stage_q;
    assign standby          = stby_q;
    assign clamp_select     = clamp_q;
endmodule : bsu_top

// File: bsu_top_assertions.sv
// Port-level checker for the supply monitor control, bound to the top
`timescale 1ns/1ps
module bsu_top_chk (
    input wire logic        mclk, arst_n, reg_wr, supply_below_uv, effect_start, effect_end,
    input wire logic        wake_request, output_stage_en, standby,
    input wire logic [7:0]  reg_addr, reg_wdata, reg_rdata, supply_sample,
    input wire logic [2:0]  uv_threshold_sel,
    input wire logic [11:0] uv_threshold_mv,
    input wire logic [1:0]  clamp_select
);
    logic [23:0] sh_q, sh_d;
    logic [7:0]  rd_e;
    logic [1:0]  cl_e;
    // Shadow of config, level one and level two, in that order
    always_comb begin
        sh_d = sh_q;
        if (reg_wr && reg_addr == 8'h09) sh_d[23:16] = reg_wdata;
        if (reg_wr && reg_addr == 8'h0A) sh_d[15:8] = reg_wdata;
        if (reg_wr && reg_addr == 8'h0B) sh_d[7:0] = reg_wdata;
        rd_e = (reg_addr == 8'h09) ? sh_q[23:16] : (reg_addr == 8'h0A) ? sh_q[15:8] :
               (reg_addr == 8'h0B) ? sh_q[7:0] : 8'h00;
        cl_e = (sh_q[23:22] == 2'h2 && supply_sample < sh_q[7:0]) ? 2'h2 :
               (^sh_q[23:22] && supply_sample < sh_q[15:8]) ? 2'h1 : 2'h0;
    end
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) sh_q <= 24'h00928D;
        else sh_q <= sh_d;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    sequence s_start;
        effect_start && wake_request && !standby && !output_stage_en && !supply_below_uv;
    endsequence
    sequence s_cfg_wr;
        reg_wr && reg_addr == 8'h09 ##1 !reg_wr;
    endsequence
    a_uv_shut_off: assert property (supply_below_uv |=>
        !output_stage_en && standby && clamp_select == 2'h0) else $error("no lockout");
    a_stage_excl: assert property (!(output_stage_en && standby))
        else $error("stage on in standby");
    a_start_clamp: assert property (s_start |=>
        output_stage_en && clamp_select == $past(cl_e)) else $error("wrong clamp");
    a_clamp_held: assert property (output_stage_en && !effect_end && !supply_below_uv |=>
        output_stage_en && $stable(clamp_select)) else $error("clamp moved");
    a_end_clear: assert property (output_stage_en && effect_end && !supply_below_uv |=>
        !output_stage_en && clamp_select == 2'h0) else $error("effect end ignored");
    a_uv_level: assert property ($stable(uv_threshold_sel) [*2] |->
        uv_threshold_mv == 12'h9C4 + 12'h064 * uv_threshold_sel) else $error("bad level");
    a_sel_cfg: assert property (s_cfg_wr |=>
        {5'h00, uv_threshold_sel} == ($past(reg_wdata, 2) & 8'h07)) else $error("bad select");
    a_read_data: assert property (1'b1 |=> reg_rdata == $past(rd_e))
        else $error("bad read data");
endmodule : bsu_top_chk
bind bsu_top bsu_top_chk u_chk (.mclk, .arst_n, .reg_wr, .supply_below_uv, .effect_start,
    .effect_end, .wake_request, .output_stage_en, .standby, .reg_addr, .reg_wdata, .reg_rdata,
    .supply_sample, .uv_threshold_sel, .uv_threshold_mv, .clamp_select);

// File: bsu_host_model.sv
// Host side: register writes and reads over the plain register port
`timescale 1ns/1ps
module bsu_host_model (
    input  wire logic       mclk,      // Core clock
    input  wire logic [7:0] reg_rdata, // Read data
    output logic            reg_wr,    // Write strobe
    output logic      [7:0] reg_addr,  // Offset
    output logic      [7:0] reg_wdata  // Write data
);
    initial begin
        reg_wr = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask : wr
    // Callers hand level one above level two; clamp values live outside this block
    task automatic thr(input logic [7:0] one, input logic [7:0] two);
        wr(8'h0A, one);
        wr(8'h0B, two);
    endtask : thr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        @(posedge mclk);
        #1 d = reg_rdata;
    endtask : rd
endmodule : bsu_host_model

// File: tb_top.sv
// Self-checking bench: register map, lockout and clamp selection
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin fail_count++; \
    $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module tb_top;
    logic        mclk = 1'b0, arst_n = 1'b0, reg_wr, supply_below_uv = 1'b0;
    logic        effect_start = 1'b0, effect_end = 1'b0, wake_request = 1'b0;
    logic        output_stage_en, standby;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, supply_sample = 8'h00, rd, t1, t2, cfg;
    logic [7:0]  pick [5];
    logic [2:0]  uv_threshold_sel;
    logic [11:0] uv_threshold_mv;
    logic [1:0]  clamp_select, e;
    int          fail_count = 0, check_count = 0, seed = 84747;
    always #25 mclk = ~mclk;
    bsu_host_model u_host (.mclk, .reg_rdata, .reg_wr, .reg_addr, .reg_wdata);
    bsu_top i_bsu_top (.mclk, .arst_n, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata,
        .supply_below_uv, .supply_sample, .effect_start, .effect_end, .wake_request,
        .uv_threshold_sel, .uv_threshold_mv, .output_stage_en, .standby, .clamp_select);
    function automatic logic [1:0] exp_clamp(logic [1:0] en, logic [7:0] one, two, s);
        if (en == 2'h2 && s < two) return 2'h2;
        return (^en && s < one) ? 2'h1 : 2'h0;
    endfunction : exp_clamp
    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : close_out
    task automatic rchk(input logic [7:0] a, input logic [7:0] x, input string n);
        u_host.rd(a, rd);
        `CHK(n, x, rd)
    endtask : rchk
    task automatic strobe(input bit stop);
        @(posedge mclk);
        effect_start <= !stop;
        effect_end <= stop;
        @(posedge mclk);
        effect_start <= 1'b0;
        effect_end <= 1'b0;
        #1;
    endtask : strobe
    initial begin
        repeat (5) @(posedge mclk);
        arst_n <= 1'b1;
        rchk(8'h09, 8'h00, "config");
        rchk(8'h0A, 8'h92, "thr_one");
        rchk(8'h0B, 8'h8D, "thr_two");
        rchk(8'h0C, 8'h00, "unmapped");
        `CHK("rst_standby", 1'b1, standby)
        `CHK("rst_stage", 1'b0, output_stage_en)
        `CHK("rst_clamp", 2'h0, clamp_select)
        `CHK("rst_uv_mv", 12'h9C4, uv_threshold_mv)
        `CHK("rst_uv_sel", 3'h0, uv_threshold_sel)
        for (int c = 0; c < 8; c++) begin
            u_host.wr(8'h09, {5'h1C, c[2:0]});
            rchk(8'h09, {5'h1C, c[2:0]}, "config");
            `CHK("uv_mv", 12'h9C4 + 12'h064 * c[11:0], uv_threshold_mv)
            `CHK("uv_sel", c[2:0], uv_threshold_sel)
        end
        @(posedge mclk);
        wake_request <= 1'b1;
        // Samples on and just under each level catch an off-by-one compare
        for (int i = 0; i < 24; i++) begin
            t1 = {1'b1, 7'($random(seed))};
            t2 = t1 - 8'h01 - {1'b0, 7'($random(seed))};
            cfg = {i[1:0], 6'($random(seed))};
            pick = '{t1, t2, t1 - 8'h01, t2 - 8'h01, 8'($random(seed))};
            e = exp_clamp(cfg[7:6], t1, t2, pick[i % 5]);
            u_host.thr(t1, t2);
            u_host.wr(8'h09, cfg);
            supply_sample <= pick[i % 5];
            strobe(1'b0);
            `CHK("clamp", e, clamp_select)
            `CHK("stage_on", 1'b1, output_stage_en)
            @(posedge mclk);
            supply_sample <= ~supply_sample;
            repeat (3) @(posedge mclk);
            #1;
            `CHK("clamp_held", e, clamp_select)
            strobe(1'b1);
            `CHK("clamp_end", 2'h0, clamp_select)
            `CHK("stage_end", 1'b0, output_stage_en)
        end
        strobe(1'b0);
        @(posedge mclk);
        supply_below_uv <= 1'b1;
        @(posedge mclk);
        effect_start <= 1'b1;
        #1;
        `CHK("uv_stage", 1'b0, output_stage_en)
        `CHK("uv_standby", 1'b1, standby)
        `CHK("uv_clamp", 2'h0, clamp_select)
        @(posedge mclk);
        effect_start <= 1'b0;
        supply_below_uv <= 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        `CHK("wake", 1'b0, standby)
        `CHK("start_ignored", 1'b0, output_stage_en)
        close_out();
    end
    initial begin
        #200000;
        fail_count++;
        close_out();
    end
endmodule : tb_top
